// ### verilog/comm_pin_pkg.sv
// Shared constants and types for the channel data pin block
`default_nettype none
package comm_pin_pkg;
   localparam int CELL_OCTETS   = 53;
   localparam int OCTET_W       = 8;
   localparam int NIBBLE_W      = 4;
   localparam int FIFO_DEPTH    = 32;
   localparam int CNT_W         = 6;
   localparam logic [CNT_W-1:0] CNT_LAST  = 6'h34;
   localparam logic [CNT_W-1:0] CNT_ZERO  = 6'h00;
   localparam logic [7:0]       IDLE_OCTET = 8'h00;
   localparam logic [7:0]       PIN_ZERO   = 8'h00;
   localparam int SER_PIN       = 7;
   localparam int NIB_LO_PIN    = 4;
   localparam logic [1:0]       BIT_ZERO2 = 2'h0;
   localparam logic [2:0]       BIT_LAST3 = 3'h7;
   localparam logic [2:0]       BIT_ZERO3 = 3'h0;
   localparam logic [1:0]       NIB_LAST  = 2'h1;

   typedef enum logic [3:0] {
      MODE_OFF    = 4'h1,
      MODE_CELL   = 4'h2,
      MODE_NIBBLE = 4'h4,
      MODE_SERIAL = 4'h8
   } chan_mode_t;

   typedef struct packed {
      logic [7:0] data;
      logic       soc;
   } rx_word_t;
endpackage
`default_nettype wire

// ### verilog/comm_fifo.sv
// Parameterised valid/ready FIFO
`timescale 1ns/100ps
`default_nettype none
module comm_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input  wire logic             i_mclk,
   input  wire logic             i_reset,
   input  wire logic [WIDTH-1:0] i_data,
   input  wire logic             i_valid,
   output var  logic             o_ready,
   output var  logic [WIDTH-1:0] o_data,
   output var  logic             o_valid,
   input  wire logic             i_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic             push;
   logic             pop;
   logic [AW:0]      next_count;

   assign o_valid = (count != '0);
   assign o_data  = mem[rd_ptr];
   assign push    = i_valid && o_ready;
   assign pop     = o_valid && i_ready;
   assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);

   always_ff @(posedge i_mclk) begin
      if (push) begin
         mem[wr_ptr] <= i_data;
      end
   end

   // Ready is a flop so that a pin-level ready never comes through logic
   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         wr_ptr  <= '0;
         rd_ptr  <= '0;
         count   <= '0;
         o_ready <= 1'b1;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         count   <= next_count;
         o_ready <= (next_count != (AW+1)'(DEPTH));
      end
   end
endmodule
`default_nettype wire

// ### verilog/fast_comm_channel_one_pins.sv
// Data pin mux of the first fast communications channel
// Notes on behaviour
// - Cell octets out, bit 7 most significant
// - Idle cells fill gaps without payload
// - Every cell is exactly 53 octets
// - Nibbles out, bit 0 on pin 7, bit 3 on pin 4
// - Serial output shares cell bit 7 pin
// - Cell octets captured, bit 7 most significant
// - Receive bus never driven by this block
// - Nibbles in, bit 0 from pin 7, bit 3 from pin 4
// - Serial input shares cell bit 7 pin
// - Nibble bits map reversed onto cell 4..7
// - Start-of-cell flags first receive octet
`timescale 1ns/100ps
`default_nettype none
module fast_comm_channel_one_pins
   import comm_pin_pkg::*;
(
   input  wire logic                i_mclk,
   input  wire logic                i_reset,
   input  wire chan_mode_t          i_mode,
   input  wire logic [OCTET_W-1:0]  i_tx_data,
   input  wire logic                i_tx_valid,
   output var  logic                o_tx_ready,
   output var  logic [OCTET_W-1:0]  o_tx_pins,
   output var  logic [OCTET_W-1:0]  o_tx_pins_oe_n,
   output var  logic                o_tx_soc,
   input  wire logic [OCTET_W-1:0]  i_rx_pins,
   input  wire logic                i_rx_enable,
   input  wire logic                i_rx_soc_in,
   output var  logic [OCTET_W-1:0]  o_rx_pins_oe_n,
   output var  logic                o_rx_soc_out,
   output var  logic                o_rx_valid,
   output var  rx_word_t            o_rx_word
);
   logic [OCTET_W-1:0] f_data;
   logic               f_valid;
   logic               f_pop;
   logic [CNT_W-1:0]   cell_cnt;
   logic               cell_is_data;
   logic               cell_data;
   logic [2:0]         bit_idx;
   logic [1:0]         nib_idx;
   logic [OCTET_W-1:0] rx_shift;

   function automatic logic [OCTET_W-1:0] nib_to_pins(input logic [NIBBLE_W-1:0] n);
      logic [OCTET_W-1:0] p;
      p = PIN_ZERO;
      for (int k = 0; k < NIBBLE_W; k++) begin
         p[SER_PIN-k] = n[k];
      end
      return p;
   endfunction

   comm_fifo #(.WIDTH(OCTET_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .i_mclk  (i_mclk),
      .i_reset (i_reset),
      .i_data  (i_tx_data),
      .i_valid (i_tx_valid),
      .o_ready (o_tx_ready),
      .o_data  (f_data),
      .o_valid (f_valid),
      .i_ready (f_pop)
   );

   // The buffer is shorter than a cell, so a data cell opens on any buffered octet;
   // a writer that falls behind gets idle octets as padding, the cell stays 53 long
   always_comb begin
      cell_data = (cell_cnt == CNT_ZERO) ? f_valid : cell_is_data;
   end

   // Payload is taken once per octet in cell mode, once per two nibbles or eight bits
   always_comb begin
      f_pop = 1'b0;
      case (i_mode)
         MODE_CELL:   f_pop = cell_data && f_valid;
         MODE_NIBBLE: f_pop = f_valid && (nib_idx == NIB_LAST);
         MODE_SERIAL: f_pop = f_valid && (bit_idx == BIT_LAST3);
         MODE_OFF:    f_pop = 1'b0;
         default:     f_pop = 1'b0;
      endcase
   end

   // Cell octet counter
   always_ff @(posedge i_mclk) begin
      if (i_reset || i_mode != MODE_CELL) begin
         cell_cnt <= CNT_ZERO;
      end else if (cell_cnt == CNT_LAST) begin
         cell_cnt <= CNT_ZERO;
      end else begin
         cell_cnt <= cell_cnt + 1'b1;
      end
   end

   // Data or idle is chosen once per cell, at octet 0
   always_ff @(posedge i_mclk) begin
      if (i_reset || i_mode != MODE_CELL) begin
         cell_is_data <= 1'b0;
      end else if (cell_cnt == CNT_ZERO) begin
         cell_is_data <= f_valid;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_reset || i_mode != MODE_SERIAL) begin
         bit_idx <= BIT_ZERO3;
      end else if (f_valid) begin
         bit_idx <= bit_idx + 1'b1;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_reset || i_mode != MODE_NIBBLE) begin
         nib_idx <= BIT_ZERO2;
      end else if (f_valid) begin
         nib_idx <= (nib_idx == NIB_LAST) ? BIT_ZERO2 : nib_idx + 1'b1;
      end
   end

   // Transmit pins: unused pins released for general use
   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         o_tx_pins      <= PIN_ZERO;
         o_tx_pins_oe_n <= '1;
         o_tx_soc       <= 1'b0;
      end else begin
         o_tx_soc <= 1'b0;
         case (i_mode)
            MODE_CELL: begin
               o_tx_pins      <= (cell_data && f_valid) ? f_data : IDLE_OCTET;
               o_tx_pins_oe_n <= PIN_ZERO;
               o_tx_soc       <= (cell_cnt == CNT_ZERO);
            end
            MODE_NIBBLE: begin
               o_tx_pins <= nib_to_pins(nib_idx[0] ? f_data[3:0] : f_data[7:4]);
               o_tx_pins_oe_n <= {{NIBBLE_W{1'b0}}, {NIBBLE_W{1'b1}}};
            end
            MODE_SERIAL: begin
               o_tx_pins          <= PIN_ZERO;
               o_tx_pins[SER_PIN] <= f_data[BIT_LAST3 - bit_idx];
               o_tx_pins_oe_n     <= ~(8'h80);
            end
            default: begin
               o_tx_pins      <= PIN_ZERO;
               o_tx_pins_oe_n <= '1;
            end
         endcase
      end
   end

   // Receive side; the device never drives the receive bus itself
   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         o_rx_pins_oe_n <= '1;
         o_rx_soc_out   <= 1'b0;
         o_rx_valid     <= 1'b0;
         o_rx_word      <= '0;
         rx_shift       <= PIN_ZERO;
      end else begin
         o_rx_pins_oe_n <= '1;
         o_rx_valid     <= 1'b0;
         o_rx_soc_out   <= 1'b0;
         case (i_mode)
            MODE_CELL: begin
               if (i_rx_enable) begin
                  o_rx_word.data <= i_rx_pins;
                  o_rx_word.soc  <= i_rx_soc_in;
                  o_rx_soc_out   <= i_rx_soc_in;
                  o_rx_valid     <= 1'b1;
               end
            end
            MODE_NIBBLE: begin
               o_rx_word.data <= {PIN_ZERO[7:4],
                  i_rx_pins[4], i_rx_pins[5], i_rx_pins[6], i_rx_pins[7]};
               o_rx_word.soc  <= 1'b0;
               o_rx_valid     <= 1'b1;
            end
            MODE_SERIAL: begin
               rx_shift       <= {rx_shift[6:0], i_rx_pins[SER_PIN]};
               o_rx_word.data <= {rx_shift[6:0], i_rx_pins[SER_PIN]};
               o_rx_word.soc  <= 1'b0;
               o_rx_valid     <= 1'b1;
            end
            default: begin
               o_rx_word <= '0;
            end
         endcase
      end
   end

   AST_CELL_LEN: assert property (@(posedge i_mclk) disable iff (i_reset)
      (i_mode == MODE_CELL && cell_cnt == CNT_LAST) |=> cell_cnt == CNT_ZERO)
      else $error("cell not 53 octets");
   AST_IDLE: assert property (@(posedge i_mclk) disable iff (i_reset)
      (i_mode == MODE_CELL && $stable(i_mode) && !(cell_data && f_valid))
      |=> o_tx_pins == IDLE_OCTET)
      else $error("idle octet wrong");
   AST_TX_OCTET: assert property (@(posedge i_mclk) disable iff (i_reset)
      (i_mode == MODE_CELL && cell_data && f_valid) |=> o_tx_pins == $past(f_data))
      else $error("cell octet wrong");
   AST_SER_PIN: assert property (@(posedge i_mclk) disable iff (i_reset)
      (i_mode == MODE_SERIAL) |=> o_tx_pins[6:0] == 7'h00)
      else $error("serial uses wrong pin");
   AST_NIB_MAP: assert property (@(posedge i_mclk) disable iff (i_reset)
      (i_mode == MODE_NIBBLE && nib_idx[0]) |=> o_tx_pins[4] == $past(f_data[3]))
      else $error("nibble map wrong");
   AST_RX_TRI: assert property (@(posedge i_mclk) disable iff (i_reset)
      ##1 o_rx_pins_oe_n == 8'hff)
      else $error("receive bus driven");
   AST_RX_OCTET: assert property (@(posedge i_mclk) disable iff (i_reset)
      (i_mode == MODE_CELL && i_rx_enable) |=> o_rx_valid
      && o_rx_word.data == $past(i_rx_pins))
      else $error("rx octet wrong");
   AST_RX_SOC: assert property (@(posedge i_mclk) disable iff (i_reset)
      (i_mode == MODE_CELL && i_rx_enable && i_rx_soc_in) |=> o_rx_soc_out)
      else $error("rx start of cell lost");
   AST_RX_NIB: assert property (@(posedge i_mclk) disable iff (i_reset)
      (i_mode == MODE_NIBBLE) |=> o_rx_word.data[0] == $past(i_rx_pins[7]))
      else $error("rx nibble wrong");
   AST_OFF: assert property (@(posedge i_mclk) disable iff (i_reset)
      (i_mode == MODE_OFF) |=> o_tx_pins_oe_n == 8'hff)
      else $error("pins not released");
   AST_RX_SER: assert property (@(posedge i_mclk) disable iff (i_reset)
      (i_mode == MODE_SERIAL) |=> o_rx_word.data[0] == $past(i_rx_pins[7]))
      else $error("rx serial wrong");
   AST_NIB_OUT: assert property (@(posedge i_mclk) disable iff (i_reset)
      (i_mode == MODE_NIBBLE) |=> o_tx_pins_oe_n == 8'h0f)
      else $error("nibble pins wrong");

   COV_DATA_CELL: cover property (@(posedge i_mclk) cell_is_data && cell_cnt == CNT_LAST);
   COV_IDLE_CELL: cover property (@(posedge i_mclk)
      i_mode == MODE_CELL && !cell_is_data && cell_cnt == CNT_LAST);
   COV_FIFO_FULL: cover property (@(posedge i_mclk) !o_tx_ready);
   COV_RX_SOC: cover property (@(posedge i_mclk) o_rx_soc_out);
endmodule
`default_nettype wire

// ### tb/phy_model.sv
// External physical layer device driving the receive pins
`timescale 1ns/100ps
`default_nettype none
module phy_model (
   input  wire logic       i_mclk,
   input  wire logic       i_drive_en,
   input  wire logic [7:0] i_octet,
   output var  logic [7:0] o_pins
);
   logic [7:0] junk = 8'h5a;
   // A released bus shows a changing pattern, never a stale octet
   always_ff @(posedge i_mclk) begin
      junk <= ~junk;
   end
   always_comb begin
      o_pins = i_drive_en ? i_octet : junk;
   end
endmodule
`default_nettype wire

// ### tb/tb_fast_comm_channel_one_pins.sv
// Self-checking bench for the channel data pin mux
`timescale 1ns/100ps
`default_nettype none
module tb_fast_comm_channel_one_pins;
   import comm_pin_pkg::*;
   logic       clk = 1'b0;
   logic       rst = 1'b1;
   chan_mode_t mode = MODE_OFF;
   logic [7:0] txd = 8'h00;
   logic       txv = 1'b0;
   logic       rxen = 1'b0;
   logic       receive_start_of_cell = 1'b0;
   logic [7:0] oct = 8'h00;
   logic [7:0] txp, txoe, rxp, rxoe;
   logic       rdy, txsoc, socout, rxv;
   rx_word_t   rxw;
   int         n_fail = 0;
   int         cmp_count = 0;

   fast_comm_channel_one_pins u_fast_comm_channel_one_pins (
      .i_mclk(clk), .i_reset(rst), .i_mode(mode), .i_tx_data(txd), .i_tx_valid(txv),
      .o_tx_ready(rdy), .o_tx_pins(txp), .o_tx_pins_oe_n(txoe), .o_tx_soc(txsoc),
      .i_rx_pins(rxp), .i_rx_enable(rxen), .i_rx_soc_in(receive_start_of_cell), .o_rx_pins_oe_n(rxoe),
      .o_rx_soc_out(socout), .o_rx_valid(rxv), .o_rx_word(rxw));
   phy_model u_phy_model (.i_mclk(clk), .i_drive_en(rxen), .i_octet(oct), .o_pins(rxp));

   initial begin
      forever #50 clk = ~clk;
   end

   task automatic results;
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask

   task automatic tick;
      @(negedge clk);
   endtask

   task automatic do_reset;
      rst = 1'b1;
      repeat (2) tick();
      rst = 1'b0;
   endtask

   task automatic push(input logic [7:0] b);
      txd = b;
      txv = 1'b1;
      tick();
   endtask

   // Fill the buffer until it refuses, then drain the head octets nibble by nibble
   task automatic t_fill_nibble;
      int n;
      for (int i = 0; i < FIFO_DEPTH; i++) push({4'(i + 1), 4'hc});
      txv = 1'b0;
      chk("tx_ready_full", 8'h00, {7'h0, rdy});
      mode = MODE_NIBBLE;
      n = 0;
      while ((txp & 8'hf0) === 8'h00 && n < 20) begin
         tick();
         n++;
      end
      chk("nib_hi", 8'h80, txp & 8'hf0);
      tick();
      chk("nib_lo", 8'h30, txp & 8'hf0);
      chk("nib_oe", 8'h0f, txoe);
      tick();
      chk("nib_hi2", 8'h40, txp & 8'hf0);
      tick();
      chk("nib_lo2", 8'h30, txp & 8'hf0);
      tick();
      chk("nib_hi3", 8'hc0, txp & 8'hf0);
   endtask

   task automatic t_serial;
      logic [7:0] s;
      int         n;
      do_reset();
      mode = MODE_SERIAL;
      push(8'h83);
      txv = 1'b0;
      n = 0;
      while (txp[SER_PIN] !== 1'b1 && n < 20) begin
         tick();
         n++;
      end
      for (int i = 0; i < 8; i++) begin
         s = {s[6:0], txp[SER_PIN]};
         tick();
      end
      chk("ser_bits", 8'h83, s);
      chk("ser_oe", 8'h7f, txoe);
   endtask

   // With nothing buffered, idle cells of 53 octets repeat back to back
   task automatic t_idle_cells;
      int n;
      do_reset();
      mode = MODE_CELL;
      n = 0;
      while (txsoc !== 1'b1 && n < 60) begin
         tick();
         n++;
      end
      tick();
      n = 1;
      while (txsoc !== 1'b1 && n < 100) begin
         chk("idle_octet", IDLE_OCTET, txp);
         tick();
         n++;
      end
      chk("cell_len", 8'(CELL_OCTETS), 8'(n));
      chk("cell_oe", 8'h00, txoe);
      // Octets queued mid-cell open the next cell, the rest of it is padded
      push(8'h81);
      push(8'h42);
      push(8'h17);
      txv = 1'b0;
      n = 0;
      while (txsoc !== 1'b1 && n < 60) begin
         tick();
         n++;
      end
      chk("cell_oct0", 8'h81, txp);
      tick();
      chk("cell_oct1", 8'h42, txp);
      tick();
      chk("cell_oct2", 8'h17, txp);
      tick();
      chk("cell_pad", IDLE_OCTET, txp);
   endtask

   task automatic t_rx;
      int n;
      do_reset();
      mode = MODE_CELL;
      oct = 8'h3c;
      receive_start_of_cell = 1'b1;
      rxen = 1'b1;
      n = 0;
      while (rxv !== 1'b1 && n < 5) begin
         tick();
         n++;
      end
      chk("rx_octet", 8'h3c, rxw.data);
      chk("rx_soc", 8'h03, {6'h0, socout, rxw.soc});
      rxen = 1'b0;
      receive_start_of_cell = 1'b0;
      repeat (2) tick();
      n = 0;
      for (int i = 0; i < 10; i++) begin
         n += int'(rxv === 1'b1);
         tick();
      end
      chk("rx_gated", 8'h00, 8'(n));
      chk("rx_oe", 8'hff, rxoe);
      mode = MODE_NIBBLE;
      rxen = 1'b1;
      oct = 8'h50;
      repeat (4) tick();
      chk("rx_nib", 8'h0a, {4'h0, rxw.data[3:0]});
      mode = MODE_SERIAL;
      oct = 8'h80;
      repeat (10) tick();
      chk("rx_ser", 8'hff, rxw.data);
   endtask

   initial begin
      repeat (12) tick();
      rst = 1'b0;
      chk("rst_tx_oe", 8'hff, txoe);
      chk("rst_rx_oe", 8'hff, rxoe);
      t_fill_nibble();
      t_serial();
      t_idle_cells();
      t_rx();
      results();
   end

   // Whole run needs well under a thousand cycles
   initial begin
      #(20000 * 100);
      n_fail++;
      results();
   end
endmodule
`default_nettype wire
